// File: design/meer_top.v
// memory error event router: status flags, enables, error log and message generation
`timescale 1ns/1ps
`include "meer_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - lock to memory outside dram sets status bit 9.
// - 1024 queued refresh requests set status bit 8.
// - throttle condition sets status bit 7; zero means cleared since.
// - multi-bit ecc read sets bit 1 and logs address, channel, device.
// - log fields frozen while multi-bit flag set until written one.
// - single-bit ecc sets bit 0 and logs address and device.
// - single-bit flag blocks further single-bit logging; multi-bit overwrites.
// - ecc flags clear only by reset or software write of one.
// - enabled flag rising sends system error if globally enabled.
// - enable bits sit at the same positions as status flags.
// - smi enable bits 1 and 0 send smi for ecc errors.
// - sci enable bits 1 and 0 send sci for ecc errors.
// - messages only on zero-to-one flag transitions.
// - flags other than thermal set regardless of message enables.
// - thermal flag set only when a message was sent; none while set.
module meer_top #(
	parameter AW = 32,
	parameter SW = 8
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [9:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	// memory controller events, same clock
	input  wire        lock_nonmem_i,
	input  wire        refresh_enq_i,
	input  wire        refresh_deq_i,
	input  wire        throttle_i,
	input  wire        thermal_trip_i,
	input  wire        sbe_i,
	input  wire        mbe_i,
	input  wire [AW-1:0] err_addr_i,
	input  wire [7:0]  err_chan_i,
	input  wire [7:0]  err_dev_i,
	input  wire [SW-1:0] err_syn_i,
	// downstream message link
	output wire        msg_serr_o,
	output wire        msg_smi_o,
	output wire        msg_sci_o
);

	////////////////////////////////////////////////////////////////////////////
	// registers
	reg  [15:0] status_q;
	reg  [15:0] error_message_enable_q;
	reg  [15:0] smi_message_enable_q;
	reg  [15:0] sci_message_enable_q;
	reg         serr_global_q;
	reg  [10:0] refq_q;
	reg         rto_armed_q;
	reg  [15:0] status_d;
	reg  [15:0] set_vec;
	reg  [15:0] clr_vec;
	reg  [10:0] refq_d;
	reg  [31:0] rd_data;
	reg         hit;
	wire [AW-1:0] log_addr;
	wire [7:0]  log_chan;
	wire [7:0]  log_dev;
	wire [SW-1:0] log_syn;
	wire        req;
	wire        wr;
	wire [7:0]  idx;
	wire        therm_msg;
	wire        wr_status;
	wire        wr_error_message_enable;
	wire        wr_smi_message_enable;
	wire        wr_sci_message_enable;
	wire        wr_global;
	wire        lock_evt;
	wire        throt_evt;
	wire        mbe_evt;
	wire        sbe_evt;
	wire        rto_evt;
	wire        rto_at_limit;
	wire        refq_full;
	wire        refq_empty;
	wire        therm_serr_ok;
	wire        ans_ok;
	wire        ans_bad;
	wire        rd_take;

	// byte-lane write merge of a 16-bit register in the low half
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] dat;
		input [3:0]  sel;
		begin
			merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
			merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
		end
	endfunction

	// a request is taken only while no answer is pending, so a held strobe is not served twice
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr  = req && wb_we_i;
	assign idx = wb_adr_i[9:2];

	// one write strobe per register, live for the single cycle in which the request is taken
	assign wr_status = wr && (idx == `MEER_IDX_STATUS);
	assign wr_error_message_enable = wr && (idx == `MEER_IDX_ERROR_MESSAGE_ENABLE);
	assign wr_smi_message_enable = wr && (idx == `MEER_IDX_SMI_MESSAGE_ENABLE);
	assign wr_sci_message_enable = wr && (idx == `MEER_IDX_SCI_MESSAGE_ENABLE);
	assign wr_global = wr && (idx == `MEER_IDX_GLOBAL) && wb_sel_i[0];

	////////////////////////////////////////////////////////////////////////////
	// refresh queue depth limits; the count saturates instead of wrapping
	assign refq_full  = (refq_q == `MEER_RTO_LIMIT);
	assign refq_empty = (refq_q == `MEER_RST_REFQ);

	// refresh queue depth; an enqueue and a service in one cycle cancel out
	always @* begin
		refq_d = refq_q;
		if (refresh_enq_i && !refresh_deq_i && !refq_full)
			refq_d = refq_q + `MEER_REFQ_STEP;
		else if (refresh_deq_i && !refresh_enq_i && !refq_empty)
			refq_d = refq_q - `MEER_REFQ_STEP;
	end

	// the timeout fires once per arrival at the limit, not on every cycle spent there
	assign rto_at_limit = (refq_d == `MEER_RTO_LIMIT);
	assign rto_evt      = rto_at_limit && !rto_armed_q;

	////////////////////////////////////////////////////////////////////////////
	// event sources, all on the host clock, so they need no synchroniser
	assign lock_evt  = lock_nonmem_i;
	assign throt_evt = throttle_i;
	assign mbe_evt   = mbe_i;
	assign sbe_evt   = sbe_i;

	// an error_message_enable enable alone sends nothing while the global serr permission is off
	assign therm_serr_ok = error_message_enable_q[`MEER_BIT_THERM] && serr_global_q;

	// thermal flag records only a trip that really sends a message, and blocks repeats
	assign therm_msg = thermal_trip_i && !status_q[`MEER_BIT_THERM] &&
		(therm_serr_ok || smi_message_enable_q[`MEER_BIT_THERM] || sci_message_enable_q[`MEER_BIT_THERM]);

	////////////////////////////////////////////////////////////////////////////
	// status flag set and clear
	always @* begin
		set_vec = 16'h0000;
		set_vec[`MEER_BIT_LOCK]  = lock_evt;
		set_vec[`MEER_BIT_RTO]   = rto_evt;
		set_vec[`MEER_BIT_THROT] = throt_evt;
		set_vec[`MEER_BIT_MBE]   = mbe_evt;
		set_vec[`MEER_BIT_SBE]   = sbe_evt;
		set_vec[`MEER_BIT_THERM] = therm_msg;
		clr_vec = 16'h0000;
		if (wr_status)
			clr_vec = merge16(16'h0000, wb_dat_i, wb_sel_i) & `MEER_MASK_STATUS;
		status_d = ((status_q & ~clr_vec) | set_vec) & `MEER_MASK_STATUS;
	end

	// status flags; a new event beats a write-one clear in the same cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= `MEER_RST_16;
		end else begin
			status_q <= status_d;
		end
	end

	// refresh queue depth and the marker that the limit was already reached
	always @(posedge clk_i) begin
		if (rst_i) begin
			refq_q      <= `MEER_RST_REFQ;
			rto_armed_q <= 1'b0;
		end else begin
			refq_q      <= refq_d;
			rto_armed_q <= rto_at_limit;
		end
	end

	// serr enables at the status bit positions; reserved positions stay zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			error_message_enable_q <= `MEER_RST_16;
		end else if (wr_error_message_enable) begin
			error_message_enable_q <= merge16(error_message_enable_q, wb_dat_i, wb_sel_i) & `MEER_MASK_ERROR_MESSAGE_ENABLE;
		end
	end

	// smi enables exist for the two ecc flags only
	always @(posedge clk_i) begin
		if (rst_i) begin
			smi_message_enable_q <= `MEER_RST_16;
		end else if (wr_smi_message_enable) begin
			smi_message_enable_q <= merge16(smi_message_enable_q, wb_dat_i, wb_sel_i) & `MEER_MASK_ECC;
		end
	end

	// sci enables exist for the two ecc flags only
	always @(posedge clk_i) begin
		if (rst_i) begin
			sci_message_enable_q <= `MEER_RST_16;
		end else if (wr_sci_message_enable) begin
			sci_message_enable_q <= merge16(sci_message_enable_q, wb_dat_i, wb_sel_i) & `MEER_MASK_ECC;
		end
	end

	// global serr permission that gates every system-error message
	always @(posedge clk_i) begin
		if (rst_i) begin
			serr_global_q <= 1'b0;
		end else if (wr_global) begin
			serr_global_q <= wb_dat_i[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// error log
	meer_log #(
		.AW (AW),
		.SW (SW)
	) u_log (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.sbe_i      (sbe_i),
		.mbe_i      (mbe_i),
		.sbe_flag_i (status_q[`MEER_BIT_SBE]),
		.mbe_flag_i (status_q[`MEER_BIT_MBE]),
		.addr_i     (err_addr_i),
		.chan_i     (err_chan_i),
		.dev_i      (err_dev_i),
		.syn_i      (err_syn_i),
		.addr_o     (log_addr),
		.chan_o     (log_chan),
		.dev_o      (log_dev),
		.syn_o      (log_syn)
	);

	////////////////////////////////////////////////////////////////////////////
	// message generation
	meer_notify u_notify (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.flags_i       (status_q),
		.serr_en_i     (error_message_enable_q),
		.smi_en_i      (smi_message_enable_q),
		.sci_en_i      (sci_message_enable_q),
		.serr_global_i (serr_global_q),
		.serr_o        (msg_serr_o),
		.smi_o         (msg_smi_o),
		.sci_o         (msg_sci_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// read mux and decode
	always @* begin
		rd_data = 32'h0000_0000;
		hit     = 1'b1;
		case (idx)
			`MEER_IDX_STATUS: rd_data[15:0] = status_q;
			`MEER_IDX_ERROR_MESSAGE_ENABLE: rd_data[15:0] = error_message_enable_q;
			`MEER_IDX_SMI_MESSAGE_ENABLE: rd_data[15:0] = smi_message_enable_q;
			`MEER_IDX_SCI_MESSAGE_ENABLE: rd_data[15:0] = sci_message_enable_q;
			`MEER_IDX_LOGADDR: rd_data[AW-1:0] = log_addr;
			`MEER_IDX_LOGINFO: begin
				rd_data[`MEER_LI_DEV_LSB +: 8]  = log_dev;
				rd_data[`MEER_LI_CH_LSB +: 8]   = log_chan;
				rd_data[`MEER_LI_SYN_LSB +: SW] = log_syn;
			end
			`MEER_IDX_GLOBAL: rd_data[0] = serr_global_q;
			`MEER_IDX_COREQ: rd_data[10:0] = refq_q;
			default: hit = 1'b0;
		endcase
	end

	// mapped index answers with ack, unmapped with err; data stays zero outside a read
	assign ans_ok  = req && hit;
	assign ans_bad = req && !hit;
	assign rd_take = ans_ok && !wb_we_i;

	// single-wait-state answer, registered so every bus output comes straight from a flop
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= ans_ok;
			wb_err_o <= ans_bad;
			wb_dat_o <= rd_take ? rd_data : 32'h0000_0000;
		end
	end

endmodule // meer_top

// File: design/meer_map.vh
// register offsets, field positions and reset values of the memory error event router
`ifndef MEER_MAP_VH
`define MEER_MAP_VH

// register indices as printed; byte address is four times the index
`define MEER_IDX_STATUS     8'hc8
`define MEER_IDX_ERROR_MESSAGE_ENABLE     8'hca
`define MEER_IDX_SMI_MESSAGE_ENABLE     8'hcc
`define MEER_IDX_SCI_MESSAGE_ENABLE     8'hce
`define MEER_IDX_LOGADDR    8'hd0
`define MEER_IDX_LOGINFO    8'hd1
`define MEER_IDX_GLOBAL     8'hd2
`define MEER_IDX_COREQ      8'hd3

// status and enable bit positions
`define MEER_BIT_SBE        0
`define MEER_BIT_MBE        1
`define MEER_BIT_THROT      7
`define MEER_BIT_RTO        8
`define MEER_BIT_LOCK       9
`define MEER_BIT_THERM      11

// writable / implemented masks
`define MEER_MASK_STATUS    16'h0b83
`define MEER_MASK_ERROR_MESSAGE_ENABLE    16'h0b83
`define MEER_MASK_ECC       16'h0003
`define MEER_RST_16         16'h0000

// refresh queue depth that flags a timeout
`define MEER_RTO_LIMIT      11'h400

// refresh queue empty value and single step
`define MEER_RST_REFQ       11'h000
`define MEER_REFQ_STEP      11'h001

// loginfo field positions
`define MEER_LI_DEV_LSB     0
`define MEER_LI_CH_LSB      8
`define MEER_LI_SYN_LSB     16

// downstream message kinds
`define MEER_MSG_SERR       2'h1
`define MEER_MSG_SMI        2'h2
`define MEER_MSG_SCI        2'h3
`define MEER_MSG_NONE       2'h0

`endif

// File: design/meer_log.v
// error log capture: address, channel, device and syndrome with freeze rules
`timescale 1ns/1ps
module meer_log #(
	parameter AW = 32,
	parameter SW = 8
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          rst_i,
	// ecc events and current flags
	input  wire          sbe_i,
	input  wire          mbe_i,
	input  wire          sbe_flag_i,
	input  wire          mbe_flag_i,
	input  wire [AW-1:0] addr_i,
	input  wire [7:0]    chan_i,
	input  wire [7:0]    dev_i,
	input  wire [SW-1:0] syn_i,
	// logged fields
	output reg  [AW-1:0] addr_o,
	output reg  [7:0]    chan_o,
	output reg  [7:0]    dev_o,
	output reg  [SW-1:0] syn_o
);

	wire take_mbe;
	wire take_sbe;

	// multi-bit overwrites a single-bit log but not a frozen multi-bit log
	assign take_mbe = mbe_i && !mbe_flag_i;
	assign take_sbe = sbe_i && !sbe_flag_i && !mbe_flag_i && !mbe_i;

	// capture registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			addr_o <= {AW{1'b0}};
			chan_o <= 8'h00;
			dev_o  <= 8'h00;
			syn_o  <= {SW{1'b0}};
		end else if (take_mbe) begin
			addr_o <= addr_i;
			chan_o <= chan_i;
			dev_o  <= dev_i;
			syn_o  <= syn_i;
		end else if (take_sbe) begin
			addr_o <= addr_i;
			dev_o  <= dev_i;
			syn_o  <= syn_i;
		end
	end

endmodule // meer_log

// File: design/meer_notify.v
// edge detection and message selection toward the downstream link
`timescale 1ns/1ps
`include "meer_map.vh"
module meer_notify (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// flags and enables
	input  wire [15:0] flags_i,
	input  wire [15:0] serr_en_i,
	input  wire [15:0] smi_en_i,
	input  wire [15:0] sci_en_i,
	input  wire        serr_global_i,
	// message strobes
	output reg         serr_o,
	output reg         smi_o,
	output reg         sci_o
);

	reg  [15:0] prev_q;
	wire [15:0] rise;

	// only a zero-to-one change of a flag produces a message
	assign rise = flags_i & ~prev_q;

	// one-cycle message strobes
	always @(posedge clk_i) begin
		if (rst_i) begin
			prev_q <= 16'h0000;
			serr_o <= 1'b0;
			smi_o  <= 1'b0;
			sci_o  <= 1'b0;
		end else begin
			prev_q <= flags_i;
			serr_o <= serr_global_i && |(rise & serr_en_i);
			smi_o  <= |(rise & smi_en_i & `MEER_MASK_ECC);
			sci_o  <= |(rise & sci_en_i & `MEER_MASK_ECC);
		end
	end

endmodule // meer_notify

// File: test/meer_link_model.sv
// downstream link receiver: turns message pulses into a received kind
`timescale 1ns/1ps
module meer_link_model (
	// message pulses from the router
	input  wire       serr_i,
	input  wire       smi_i,
	input  wire       sci_i,
	// received kind, valid while got_o
	output wire       got_o,
	output wire [1:0] kind_o
);
	// overlapping pulses merge into a wrong kind and get caught
	assign got_o  = serr_i | smi_i | sci_i;
	assign kind_o = {smi_i | sci_i, serr_i | sci_i};
endmodule // meer_link_model

// File: test/meer_top_chk.sv
// bus and message timing checks for the router top
`timescale 1ns/1ps
module meer_top_chk (
	// watched ports
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [9:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        wb_err_o,
	input wire        lock_nonmem_i,
	input wire        refresh_enq_i,
	input wire        throttle_i,
	input wire        thermal_trip_i,
	input wire        sbe_i,
	input wire        mbe_i,
	input wire        msg_serr_o,
	input wire        msg_smi_o,
	input wire        msg_sci_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// accepted request, mapped index, any event
	wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire [7:0] ix  = wb_adr_i[9:2];
	wire       map = ix == 8'hc8 | ix == 8'hca | ix == 8'hcc | ix == 8'hce | ix[7:2] == 6'h34;
	wire       ev  = lock_nonmem_i | refresh_enq_i | throttle_i | thermal_trip_i | sbe_i | mbe_i;
	property p_ack; req & map |=> wb_ack_o & !wb_err_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack after request");
	property p_err; req & !map |=> wb_err_o & !wb_ack_o; endproperty
	a_err: assert property (p_err) else $error("no err on unmapped index");
	property p_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_once: assert property (p_once) else $error("ack longer than one cycle");
	property p_dat0; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat0: assert property (p_dat0) else $error("read data outside ack");
	property p_serr; msg_serr_o |-> $past(ev, 2); endproperty
	a_serr: assert property (p_serr) else $error("serr without event");
	property p_smi; msg_smi_o |-> $past(sbe_i | mbe_i, 2); endproperty
	a_smi: assert property (p_smi) else $error("smi without ecc event");
	property p_sci; msg_sci_o |-> $past(sbe_i | mbe_i, 2); endproperty
	a_sci: assert property (p_sci) else $error("sci without ecc event");
	property p_edge; msg_serr_o |=> !msg_serr_o; endproperty
	a_edge: assert property (p_edge) else $error("serr held high");
	c_err: cover property (wb_err_o);
	c_smi: cover property (msg_smi_o);
	c_sci: cover property (msg_sci_o);
endmodule // meer_top_chk
bind meer_top meer_top_chk u_meer_top_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .wb_err_o, .lock_nonmem_i, .refresh_enq_i, .throttle_i, .thermal_trip_i, .sbe_i, .mbe_i,
	.msg_serr_o, .msg_smi_o, .msg_sci_o);

// File: test/meer_top_tb.sv
// self-checking bench for the memory error event router
`timescale 1ns/1ps
module meer_top_tb;
	reg         clk_i = 0;
	reg         rst_i = 1;
	reg         cyc   = 0;
	reg         we    = 0;
	reg  [9:0]  adr   = 0;
	reg  [31:0] wd    = 0;
	reg  [5:0]  ev    = 0;
	reg         dq    = 0;
	reg  [31:0] ea    = 0;
	reg  [23:0] es    = 0;
	reg  [31:0] seed  = 32'hdbd7703e;
	reg  [31:0] wa;
	wire [31:0] rd;
	wire        ack, err, s, m, c, got;
	wire [1:0]  kind;
	integer     errors = 0, n_checks = 0, cyc_n = 0, i;
	reg  [32:0] rq_q[$];
	reg  [1:0]  mq[$];
	// design and link receiver
	meer_top u_meer_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err),
		.lock_nonmem_i(ev[5]), .refresh_enq_i(ev[4]), .refresh_deq_i(dq), .throttle_i(ev[3]),
		.thermal_trip_i(ev[2]), .sbe_i(ev[1]), .mbe_i(ev[0]), .err_addr_i(ea), .err_chan_i(es[15:8]),
		.err_dev_i(es[7:0]), .err_syn_i(es[23:16]), .msg_serr_o(s), .msg_smi_o(m), .msg_sci_o(c));
	meer_link_model u_meer_link_model (.serr_i(s), .smi_i(m), .sci_i(c), .got_o(got), .kind_o(kind));
	always #50 clk_i = ~clk_i;
	// xorshift source for signatures
	function [31:0] xs;
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			xs = seed;
		end
	endfunction
	task chk(input [32:0] e, input [32:0] a);
		begin
			n_checks = n_checks + 1;
			if (e !== a) begin
				errors = errors + 1;
				$display("ERROR t=%0t exp=%h got=%h", $time, e, a);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// one classic cycle; a read notes its expected {err, data}
	task bus(input w, input [7:0] x, input [31:0] d, input [32:0] e);
		begin
			if (!w)
				rq_q.push_back(e);
			cyc <= 1;
			we <= w;
			adr <= {x, 2'b00};
			wd <= d;
			@(posedge clk_i);
			while ((ack | err) !== 1'b1) @(posedge clk_i);
			cyc <= 0;
			we <= 0;
			@(posedge clk_i);
		end
	endtask
	// one event pulse with a fresh signature; k is the message kind due
	task pulse(input [5:0] v, input [1:0] k);
		begin
			if (k)
				mq.push_back(k);
			ea <= xs();
			es <= xs();
			ev <= v;
			@(posedge clk_i);
			ev <= 0;
			repeat (4) @(posedge clk_i);
		end
	endtask
	// compare answers and link messages with the oldest note
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if ((ack | err) & !we)
			chk(rq_q.size() ? rq_q.pop_front() : 33'h1ffffffff, {err, rd});
		if (got)
			chk(mq.size() ? {31'h0, mq.pop_front()} : 33'h0, {31'h0, kind});
		if (cyc_n > 20000) begin
			errors = errors + 1;
			wrap_up;
		end
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		for (i = 0; i < 4; i = i + 1)
			bus(0, 8'hc8 + 2 * i, 0, 0);
		bus(1, 8'hca, 32'hffff, 0);
		bus(1, 8'hcc, 32'hffff, 0);
		bus(1, 8'hce, 32'hffff, 0);
		bus(0, 8'hca, 0, 33'h0b83);
		bus(0, 8'hcc, 0, 33'h3);
		bus(0, 8'hce, 0, 33'h3);
		bus(0, 8'h10, 0, {1'b1, 32'h0});
		bus(1, 8'hca, 32'h0b80, 0);
		bus(1, 8'hcc, 1, 0);
		bus(1, 8'hce, 2, 0);
		bus(1, 8'hd2, 1, 0);
		bus(0, 8'hd2, 0, 33'h1);
		$display("test registers done");
		pulse(6'h20, 1);
		pulse(6'h08, 1);
		pulse(6'h04, 1);
		pulse(6'h04, 0);
		pulse(6'h20, 0);
		repeat (1023) pulse(6'h10, 0);
		pulse(6'h10, 1);
		bus(0, 8'hd3, 0, 33'h400);
		dq <= 1;
		@(posedge clk_i);
		dq <= 0;
		bus(0, 8'hd3, 0, 33'h3ff);
		bus(1, 8'hc8, 32'h100, 0);
		pulse(6'h10, 1);
		bus(0, 8'hc8, 0, 33'h0b80);
		$display("test serr sources done");
		pulse(6'h02, 2);
		bus(0, 8'hd0, 0, {1'b0, ea});
		wa = ea;
		pulse(6'h02, 0);
		bus(0, 8'hd0, 0, {1'b0, wa});
		pulse(6'h01, 3);
		bus(0, 8'hd1, 0, {9'h0, es});
		wa = ea;
		pulse(6'h01, 0);
		bus(0, 8'hd0, 0, {1'b0, wa});
		bus(1, 8'hc8, 0, 0);
		bus(1, 8'hc8, 32'h2, 0);
		bus(0, 8'hc8, 0, 33'h0b81);
		pulse(6'h01, 3);
		bus(0, 8'hd0, 0, {1'b0, ea});
		$display("test ecc log done");
		bus(1, 8'hd2, 0, 0);
		bus(1, 8'hc8, 32'h200, 0);
		pulse(6'h20, 0);
		bus(0, 8'hc8, 0, 33'h0b83);
		rst_i <= 1;
		@(posedge clk_i);
		rst_i <= 0;
		bus(0, 8'hc8, 0, 0);
		$display("test gate and reset done");
		chk(0, rq_q.size() + mq.size());
		wrap_up;
	end
endmodule // meer_top_tb
